// ==== include/shp_consts.svh ====
// register map, field positions and reset values for the handler priority/state block
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH

// register byte addresses
`define SHP_ADDR_PRI0   32'hE000ED18
`define SHP_ADDR_PRI1   32'hE000ED1C
`define SHP_ADDR_PRI2   32'hE000ED20
`define SHP_ADDR_CSR    32'hE000ED24

// priority byte layout: three stored bits at the top of each byte
`define SHP_PRI_BITS    3
`define SHP_PRI_LSB     5
`define SHP_PRI_NUM     12

// control/state field positions
`define SHP_CSR_EN_LSB  16
`define SHP_CSR_PND_LSB 12

// reset values
`define SHP_RST_PRI     3'h0
`define SHP_RST_EN      3'h0
`define SHP_RST_PND     4'h0
`define SHP_RST_ACT     7'h00
`define SHP_RST_RDATA   32'h00000000

`endif

// ==== include/shp_pkg.sv ====
// types shared by the handler priority/state block
package shp_pkg;

    // one stored priority field per handler 4..15, index 0 = handler 4
    typedef logic [11:0][2:0] shp_prio_t;

    // fault handler enables, msb first as in the word
    typedef struct packed {
        logic usage_fault_enable;
        logic bus_fault_enable;
        logic memmgmt_fault_enable;
    } shp_en_t;

    // pending flags, bits 15..12 of the word
    typedef struct packed {
        logic supervisor_call_pending;
        logic bus_fault_pending;
        logic memmgmt_fault_pending;
        logic usage_fault_pending;
    } shp_pend_t;

    // active flags, msb first
    typedef struct packed {
        logic system_tick_active;
        logic pendable_service_active;
        logic debug_monitor_active;
        logic supervisor_call_active;
        logic usage_fault_active;
        logic bus_fault_active;
        logic memmgmt_fault_active;
    } shp_act_t;

    // decoded register slot of a bus access
    typedef enum logic [2:0] {
        SHP_R_PRI0 = 3'h0,
        SHP_R_PRI1 = 3'h1,
        SHP_R_PRI2 = 3'h2,
        SHP_R_CSR  = 3'h3,
        SHP_R_NONE = 3'h4
    } shp_reg_t;

endpackage : shp_pkg

// ==== design/shp_regs.sv ====
// handler priority and control/state registers on an ahb-lite slave
`timescale 1ns/1ps
`include "shp_consts.svh"

// What this block does
// - one priority byte per handler 4..15, four per word, low handler low byte
// - only the top three bits of each priority byte are stored
// - unstored priority bits read zero and ignore writes
// - usage fault priority is bits 23-21 of first word, reset zero
// - bus fault priority is bits 15-13 of first word, reset zero
// - memory management priority is bits 7-5 of first word, reset zero
// - fault enables at bits 18,17,16 of control word, reset zero
// - pending flags for svc, bus, memmgmt, usage at bits 15..12, reset zero
// - active flags for tick, service, monitor, svc at bits 11,10,8,7
// - usage, bus, memmgmt active flags at bits 3,1,0, reset zero

module shp_regs
    import shp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire shp_pend_t   core_set_pend,
    input  wire shp_pend_t   core_clr_pend,
    input  wire shp_act_t    core_set_act,
    input  wire shp_act_t    core_clr_act,
    output shp_prio_t        pri,
    output shp_en_t          en,
    output shp_pend_t        pend,
    output shp_act_t         act
);

    logic      ap_take;
    shp_reg_t  ap_reg;
    logic      dp_wr;
    shp_reg_t  dp_reg;
    shp_prio_t next_pri;
    shp_en_t   next_en;
    shp_pend_t next_pend;
    shp_act_t  next_act;
    logic      csr_wr;

    // zero wait states, never an error
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase accepted only for active transfers
    assign ap_take = hsel && htrans[1] && hready;

    // full address decode; anything else is unmapped
    always_comb begin
        case (haddr)
            `SHP_ADDR_PRI0: ap_reg = SHP_R_PRI0;
            `SHP_ADDR_PRI1: ap_reg = SHP_R_PRI1;
            `SHP_ADDR_PRI2: ap_reg = SHP_R_PRI2;
            `SHP_ADDR_CSR:  ap_reg = SHP_R_CSR;
            default:        ap_reg = SHP_R_NONE;
        endcase
    end

    // data phase bookkeeping
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_wr  <= 1'b0;
            dp_reg <= SHP_R_NONE;
        end else if (hready) begin
            dp_wr  <= ap_take && hwrite;
            dp_reg <= ap_take ? ap_reg : SHP_R_NONE;
        end
    end

    // pack a register word from field values
    function automatic logic [31:0] rd_word(
        input shp_reg_t  r,
        input shp_prio_t p,
        input shp_en_t   e,
        input shp_pend_t n,
        input shp_act_t  a
    );
        logic [31:0] w;
        w = 32'h00000000;
        case (r)
            SHP_R_PRI0, SHP_R_PRI1, SHP_R_PRI2: begin
                // low five bits of each byte stay zero
                for (int b = 0; b < 4; b++) begin
                    w[8*b+`SHP_PRI_LSB +: `SHP_PRI_BITS] = p[4*int'(r)+b];
                end
            end
            SHP_R_CSR: begin
                w = {13'h0000, e, n, a[6:5], 1'b0, a[4:3],
                     3'h0, a[2], 1'b0, a[1:0]};
            end
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction : rd_word

    // priority writes land byte by byte
    always_comb begin
        next_pri = pri;
        if (dp_wr && (dp_reg != SHP_R_CSR) && (dp_reg != SHP_R_NONE)) begin
            for (int b = 0; b < 4; b++) begin
                // only the top three bits of the byte are kept
                next_pri[4*int'(dp_reg)+b] =
                    hwdata[8*b+`SHP_PRI_LSB +: `SHP_PRI_BITS];
            end
        end
    end

    assign csr_wr = dp_wr && (dp_reg == SHP_R_CSR);

    always_comb begin
        next_en = csr_wr ? shp_en_t'(hwdata[`SHP_CSR_EN_LSB +: 3]) : en;
    end

    // pending: core set beats any software clear
    always_comb begin
        if (csr_wr) begin
            next_pend = shp_pend_t'(hwdata[`SHP_CSR_PND_LSB +: 4]);
        end else begin
            next_pend = pend & ~core_clr_pend;
        end
        next_pend = next_pend | core_set_pend;
    end

    // active flags; software may force them, stack is its problem
    always_comb begin
        if (csr_wr) begin
            // usage, bus, memmgmt taken from bits 3,1,0
            next_act = shp_act_t'({hwdata[11:10], hwdata[8:7],
                                   hwdata[3], hwdata[1:0]});
        end else begin
            next_act = act & ~core_clr_act;
        end
        next_act = next_act | core_set_act;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pri <= {`SHP_PRI_NUM{`SHP_RST_PRI}};
        end else begin
            pri <= next_pri;
        end
    end

    // control/state flag storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en   <= `SHP_RST_EN;
            pend <= `SHP_RST_PND;
            act  <= `SHP_RST_ACT;
        end else begin
            en   <= next_en;
            pend <= next_pend;
            act  <= next_act;
        end
    end

    // read data built from next values so a write just ahead is seen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= `SHP_RST_RDATA;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_word(ap_reg, next_pri, next_en, next_pend, next_act);
        end
    end

    // ---- checks ----
    logic dp_rd;

    // read data phase marker for checks only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_rd <= 1'b0;
        end else if (hready) begin
            dp_rd <= ap_take && !hwrite;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_pack_order: assert property (
        dp_rd && dp_reg == SHP_R_PRI2 |->
        hrdata == {pri[11], 5'h00, pri[10], 5'h00, pri[9], 5'h00, pri[8], 5'h00})
        else $error("priority word 2 packing wrong");

    a_prio_hold_idle: assert property (
        !dp_wr |=> $stable(pri))
        else $error("priority changed without a write");

    a_prio_low_zero: assert property (
        dp_rd && dp_reg != SHP_R_CSR |-> (hrdata & 32'h1F1F1F1F) == 32'h00000000)
        else $error("unstored priority bits read nonzero");

    a_usage_prio_wr: assert property (
        dp_wr && dp_reg == SHP_R_PRI0 |=> pri[2] == $past(hwdata[23:21]))
        else $error("usage fault priority not stored");

    a_bus_prio_wr: assert property (
        dp_wr && dp_reg == SHP_R_PRI0 |=> pri[1] == $past(hwdata[15:13]))
        else $error("bus fault priority not stored");

    a_mm_prio_wr: assert property (
        dp_wr && dp_reg == SHP_R_PRI0 |=> pri[0] == $past(hwdata[7:5]))
        else $error("memmgmt priority not stored");

    a_enable_write: assert property (
        csr_wr ##1 !csr_wr [*2] |-> en == $past(hwdata[18:16], 2))
        else $error("fault enables not kept after write");

    a_pend_set_wins: assert property (
        core_set_pend.bus_fault_pending |=> pend.bus_fault_pending)
        else $error("bus fault pending event lost");

    a_act_csr_read: assert property (
        dp_rd && dp_reg == SHP_R_CSR |->
        hrdata[11] == act.system_tick_active && hrdata[9] == 1'b0
        && hrdata[8] == act.debug_monitor_active && hrdata[31:19] == 13'h0000)
        else $error("control word active bits misplaced");

    a_fault_act_wr: assert property (
        csr_wr && core_set_act == 7'h00 && core_clr_act == 7'h00 |=>
        act.usage_fault_active == $past(hwdata[3])
        && act.memmgmt_fault_active == $past(hwdata[0]))
        else $error("fault active bits not written");

    c_csr_write:  cover property (csr_wr ##1 dp_rd && dp_reg == SHP_R_CSR);
    c_prio_write: cover property (dp_wr && dp_reg == SHP_R_PRI1);
    c_set_clear:  cover property (csr_wr && core_set_pend != 4'h0);
    c_unmapped:   cover property (dp_rd && dp_reg == SHP_R_NONE);

endmodule : shp_regs

// ==== verification/shp_core_model.sv ====
// behavioural stand-in for the core's exception entry and return logic
`timescale 1ns/1ps

module shp_core_model
    import shp_pkg::*;
(
    input  wire logic clk,
    output shp_pend_t set_pend,
    output shp_pend_t clr_pend,
    output shp_act_t  set_act,
    output shp_act_t  clr_act
);
    // quiet until the bench asks for an event
    initial begin
        set_pend = 4'h0;
        clr_pend = 4'h0;
        set_act  = 7'h00;
        clr_act  = 7'h00;
    end

    // one-cycle pulses; call just after an edge, never twice in a row
    task automatic pulse(input shp_pend_t sp, input shp_pend_t cp,
                         input shp_act_t sa, input shp_act_t ca);
        set_pend <= sp;
        clr_pend <= cp;
        set_act  <= sa;
        clr_act  <= ca;
        @(posedge clk);
        set_pend <= 4'h0;
        clr_pend <= 4'h0;
        set_act  <= 7'h00;
        clr_act  <= 7'h00;
    endtask : pulse
endmodule : shp_core_model

// ==== verification/system_handler_priority_state_bench.sv ====
// self-checking bench for the handler priority and control/state registers
`timescale 1ns/1ps
`include "shp_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module system_handler_priority_state_bench
    import shp_pkg::*;
;
    logic        clk    = 1'b0;
    logic        rst_b  = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    shp_pend_t   set_pend;
    shp_pend_t   clr_pend;
    shp_act_t    set_act;
    shp_act_t    clr_act;
    shp_prio_t   pri;
    shp_en_t     en;
    shp_pend_t   pend;
    shp_act_t    act;
    int          fails  = 0;
    int          checks = 0;
    logic [31:0] pat [3] = '{32'h3F5F7F9F, 32'hBFDFFF1F, 32'h0020C0A0};

    // 20 MHz clock
    always #25 clk = ~clk;

    shp_regs u_shp_regs (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core_set_pend(set_pend), .core_clr_pend(clr_pend), .core_set_act(set_act),
        .core_clr_act(clr_act), .pri(pri), .en(en), .pend(pend), .act(act));

    shp_core_model u_shp_core_model (.clk(clk), .set_pend(set_pend),
        .clr_pend(clr_pend), .set_act(set_act), .clr_act(clr_act));

    // one single transfer; master holds each phase until hready is seen
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h00000000, q);
        `CHK(q, e)
    endtask : rd

    task automatic results();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(`SHP_ADDR_PRI0 + 32'(4 * i), 32'h00000000);
        end
        `CHK({pri, en, pend, act}, 50'h0)
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            wr(`SHP_ADDR_PRI0 + 32'(4 * i), 32'hFFFFFFFF);
            rd(`SHP_ADDR_PRI0 + 32'(4 * i), 32'hE0E0E0E0);
            wr(`SHP_ADDR_PRI0 + 32'(4 * i), pat[i]);
            rd(`SHP_ADDR_PRI0 + 32'(4 * i), pat[i] & 32'hE0E0E0E0);
            for (int b = 0; b < 4; b++) begin
                `CHK(pri[4 * i + b], pat[i][8 * b + 5 +: 3])
            end
        end
        $display("test priority words done");
        // active flags written only while the core is quiet
        wr(`SHP_ADDR_CSR, 32'hFFFFFFFF);
        rd(`SHP_ADDR_CSR, 32'h0007FD8B);
        wr(`SHP_ADDR_CSR, 32'hFFFDA6F5);
        rd(`SHP_ADDR_CSR, 32'h0005A481);
        `CHK({en, pend, act}, {3'h5, 4'hA, 7'h29})
        $display("test control word done");
        wr(`SHP_ADDR_CSR, 32'h00000000);
        u_shp_core_model.pulse(4'h8, 4'h0, 7'h7F, 7'h00);
        rd(`SHP_ADDR_CSR, 32'h00008D8B);
        u_shp_core_model.pulse(4'h0, 4'h8, 7'h00, 7'h55);
        rd(`SHP_ADDR_CSR, 32'h00000482);
        u_shp_core_model.pulse(4'h1, 4'h1, 7'h00, 7'h00);
        rd(`SHP_ADDR_CSR, 32'h00001482);
        `CHK(pend, 4'h1)
        $display("test core events done");
        // unmapped word reads zero and keeps nothing
        wr(32'hE000ED28, 32'hFFFFFFFF);
        rd(32'hE000ED28, 32'h00000000);
        rd(`SHP_ADDR_CSR, 32'h00001482);
        $display("test unmapped done");
        // second reset in mid-run clears everything again
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(`SHP_ADDR_PRI0, 32'h00000000);
        rd(`SHP_ADDR_CSR, 32'h00000000);
        `CHK({pri, en, pend, act}, 50'h0)
        $display("test second reset done");
        results();
    end

    // watchdog well beyond the roughly 70 cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        results();
    end
endmodule : system_handler_priority_state_bench
